// *** shared/ppc_defs.svh ***
`ifndef PPC_DEFS_SVH
`define PPC_DEFS_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define PPC_OFS_CTRL 8'h00
`define PPC_OFS_TFAST 8'h04
`define PPC_OFS_TONMIN 8'h08
`define PPC_OFS_TOFFMIN 8'h0c
`define PPC_OFS_TSW 8'h10
`define PPC_OFS_HOLD 8'h14
`define PPC_OFS_RUN 8'h18
`define PPC_OFS_ACC 8'h1c
`define PPC_OFS_DEC 8'h20
`define PPC_OFS_ADCOUT 8'h24
`define PPC_OFS_STATUS 8'h28

// ****************************************************************
// Field positions
// ****************************************************************
`define PPC_CTRL_PRED_BIT 0
`define PPC_CTRL_TQREG_BIT 1
`define PPC_TFAST_MAX_LSB 4
`define PPC_TFAST_FALL_LSB 0

// ****************************************************************
// Reset values
// ****************************************************************
`define PPC_RST_CTRL 2'h0
`define PPC_RST_TFAST 8'h19
`define PPC_RST_TONMIN 7'h29
`define PPC_RST_TOFFMIN 7'h29
`define PPC_RST_TSW 5'h0b
`define PPC_RST_TVAL 7'h29

// ****************************************************************
// Timing
// ****************************************************************
`define PPC_CLK_NS 20
`define PPC_TICK_NS 500
`define PPC_TICK_CYC (`PPC_TICK_NS / `PPC_CLK_NS)
`define PPC_FAST_UNIT_NS 2000
`define PPC_FAST_UNIT_CYC (`PPC_FAST_UNIT_NS / `PPC_CLK_NS)
`define PPC_TSW_UNIT_NS 4000
`define PPC_TSW_UNIT_CYC (`PPC_TSW_UNIT_NS / `PPC_CLK_NS)
`define PPC_ADC_DIV 512
`define PPC_NBRIDGE 2
`define PPC_ADC_W 5
`define PPC_TIME_W 16

`endif

// *** shared/ppc_pkg.sv ***
package ppc_pkg;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [6:0] {
    PPC_IDLE = 7'h01,
    PPC_ON = 7'h02,
    PPC_PRED = 7'h04,
    PPC_OFF_SLOW = 7'h08,
    PPC_OFF_FAST = 7'h10,
    PPC_FAST = 7'h20,
    PPC_FALL = 7'h40
  } ppc_state_e;

  typedef enum logic [1:0] {
    PPC_MOT_STOP = 2'h0,
    PPC_MOT_ACC = 2'h1,
    PPC_MOT_DEC = 2'h2,
    PPC_MOT_RUN = 2'h3
  } ppc_motion_e;

  // Gate drive of one full bridge
  typedef struct packed {
    logic hsA;
    logic lsA;
    logic hsB;
    logic lsB;
  } ppc_gate_s;

  // Events of one bridge from the microstep sequencer
  typedef struct packed {
    logic stepRise;
    logic stepFall;
    logic zeroCross;
    logic sign;
  } ppc_step_s;

endpackage : ppc_pkg

// *** design/ppc_ctrl.sv ***
`timescale 1ns/1ps
`include "ppc_defs.svh"
// Functional notes
// - Measure sense time from turn-on each cycle
// - Predictive on equals mean of two senses
// - Fixed off time after predictive interval
// - Recompute off time on microstep change
// - Predictive disabled: off right after sense
// - Off interval is slow decay by default
// - Short on: fast decay, first is eighth
// - Repeated short on doubles fast decay
// - Fast decay doubling saturates at maximum
// - Two fast decays: split off slow/fast
// - Rising step: slow only, halve fast
// - Stop or zero crossing resets adaptation
// - Falling step applies fast decay
// - Falling decay starts at quarter setting
// - Extra falling decays double, capped
// - Falling decay carried to next step
// - Amplitude chosen by motion phase
// - Torque select picks converter or settings
// - Converter result stored each sample
// - Independent controller per bridge
// - Converter samples every 512 clocks

module ppc_ctrl (
  // System
  input wire logic clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Motion engine
  input wire logic bridgeEnable,
  input wire logic motorStopped,
  input wire ppc_pkg::ppc_motion_e motionPhase,
  input wire ppc_pkg::ppc_step_s [1:0] stepEvt,
  // Current-sense comparators, high once target reached
  input wire logic [1:0] senseHit,
  // Power bridges
  output ppc_pkg::ppc_gate_s [1:0] gate,
  output logic [6:0] amplitude,
  // Ramp converter
  input wire logic adcAbove,
  output logic [4:0] adcRamp
);

  localparam int TW = `PPC_TIME_W;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rstMeta_q;
  logic rstSyncN_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rstMeta_q <= 1'b0;
      rstSyncN_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSyncN_q <= rstMeta_q;
    end
  end

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [TW-1:0] scale(input logic [7:0] val,
                                          input logic [TW-1:0] unit);
    return TW'(({8'h00, val} + 16'h0001) * unit);
  endfunction : scale

  function automatic logic [TW-1:0] dbl(input logic [TW-1:0] val,
                                        input logic [TW-1:0] lim);
    return ({val, 1'b0} > {1'b0, lim}) ? lim : {val[TW-2:0], 1'b0};
  endfunction : dbl

  function automatic logic [TW-1:0] atLeastOne(input logic [TW-1:0] v);
    return (v == '0) ? TW'(1) : v;
  endfunction : atLeastOne

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [1:0] ctrl_q;
  logic [7:0] tfast_q;
  logic [6:0] tonMin_q;
  logic [6:0] toffMin_q;
  logic [4:0] tsw_q;
  logic [6:0] tval_q [4];
  logic [4:0] adcOut_q;
  logic [31:0] statusWord;

  wire busReq = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Writes land at the edge where the master samples ack high
  wire wrEn = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
  wire selCtrl = (wb_adr_i == `PPC_OFS_CTRL);
  wire selTfast = (wb_adr_i == `PPC_OFS_TFAST);
  wire selTon = (wb_adr_i == `PPC_OFS_TONMIN);
  wire selToff = (wb_adr_i == `PPC_OFS_TOFFMIN);
  wire selTsw = (wb_adr_i == `PPC_OFS_TSW);
  wire selHold = (wb_adr_i == `PPC_OFS_HOLD);
  wire selRun = (wb_adr_i == `PPC_OFS_RUN);
  wire selAcc = (wb_adr_i == `PPC_OFS_ACC);
  wire selDec = (wb_adr_i == `PPC_OFS_DEC);
  wire selAdc = (wb_adr_i == `PPC_OFS_ADCOUT);
  wire selStat = (wb_adr_i == `PPC_OFS_STATUS);

  logic [31:0] rdMux;
  assign rdMux =
    selCtrl ? {30'h0, ctrl_q} :
    selTfast ? {24'h0, tfast_q} :
    selTon ? {25'h0, tonMin_q} :
    selToff ? {25'h0, toffMin_q} :
    selTsw ? {27'h0, tsw_q} :
    selHold ? {25'h0, tval_q[ppc_pkg::PPC_MOT_STOP]} :
    selRun ? {25'h0, tval_q[ppc_pkg::PPC_MOT_RUN]} :
    selAcc ? {25'h0, tval_q[ppc_pkg::PPC_MOT_ACC]} :
    selDec ? {25'h0, tval_q[ppc_pkg::PPC_MOT_DEC]} :
    selAdc ? {27'h0, adcOut_q} :
    selStat ? statusWord : 32'h0;

  // Unmapped addresses are acked; reads give zero, writes are dropped
  always_ff @(posedge clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= busReq;
      wb_dat_o <= busReq ? rdMux : 32'h0;
    end
  end

  always_ff @(posedge clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      ctrl_q <= `PPC_RST_CTRL;
      tfast_q <= `PPC_RST_TFAST;
      tonMin_q <= `PPC_RST_TONMIN;
      toffMin_q <= `PPC_RST_TOFFMIN;
      tsw_q <= `PPC_RST_TSW;
      for (int k = 0; k < 4; k++) begin
        tval_q[k] <= `PPC_RST_TVAL;
      end
    end else if (wrEn) begin
      if (selCtrl) begin
        ctrl_q <= wb_dat_i[1:0];
      end else if (selTfast) begin
        tfast_q <= wb_dat_i[7:0];
      end else if (selTon) begin
        tonMin_q <= wb_dat_i[6:0];
      end else if (selToff) begin
        toffMin_q <= wb_dat_i[6:0];
      end else if (selTsw) begin
        tsw_q <= wb_dat_i[4:0];
      end else if (selHold) begin
        tval_q[ppc_pkg::PPC_MOT_STOP] <= wb_dat_i[6:0];
      end else if (selRun) begin
        tval_q[ppc_pkg::PPC_MOT_RUN] <= wb_dat_i[6:0];
      end else if (selAcc) begin
        tval_q[ppc_pkg::PPC_MOT_ACC] <= wb_dat_i[6:0];
      end else if (selDec) begin
        tval_q[ppc_pkg::PPC_MOT_DEC] <= wb_dat_i[6:0];
      end
    end
  end

  // ****************************************************************
  // Shared control parameters in clock counts
  // ****************************************************************
  wire predEn = ctrl_q[`PPC_CTRL_PRED_BIT];
  wire tqReg = ctrl_q[`PPC_CTRL_TQREG_BIT];
  wire [TW-1:0] tonMinCyc =
    scale({1'b0, tonMin_q}, TW'(`PPC_TICK_CYC));
  wire [TW-1:0] toffMinCyc = scale({1'b0, toffMin_q}, TW'(`PPC_TICK_CYC));
  wire [TW-1:0] tswCyc = scale({3'h0, tsw_q}, TW'(`PPC_TSW_UNIT_CYC));
  wire [TW-1:0] fastMaxCyc =
    scale({4'h0, tfast_q[`PPC_TFAST_MAX_LSB +: 4]},
          TW'(`PPC_FAST_UNIT_CYC));
  wire [TW-1:0] fallMaxCyc =
    scale({4'h0, tfast_q[`PPC_TFAST_FALL_LSB +: 4]},
          TW'(`PPC_FAST_UNIT_CYC));
  wire [TW-1:0] fastInit = atLeastOne(fastMaxCyc >> 3);
  wire [TW-1:0] fallInit = atLeastOne(fallMaxCyc >> 2);

  // ****************************************************************
  // Per-bridge current controller
  // ****************************************************************
  ppc_pkg::ppc_state_e state_q [2];
  logic [1:0] fastCnt_q [2];

  for (genvar i = 0; i < `PPC_NBRIDGE; i++) begin : gBridge
    ppc_pkg::ppc_state_e state_d;
    logic [TW-1:0] cnt_q, cnt_d;
    logic [TW-1:0] sense_q, sense_d;
    logic [TW-1:0] fastDur_q, fastDur_d;
    logic [TW-1:0] fallDur_q, fallDur_d;
    logic [TW-1:0] offDur_q, offDur_d;
    logic [TW-1:0] onLast_q, onLast_d;
    logic [1:0] fastCnt_d;
    logic fallAct_q, fallAct_d, primed_q;
    ppc_pkg::ppc_gate_s gate_d;
    logic [TW:0] predSum;
    logic [TW-1:0] nextFast, nextFall, offCalc, slowLen;
    logic cntDone, shortOn, adaptClr;

    assign cntDone = (cnt_q <= TW'(1));
    assign shortOn = (cnt_q < tonMinCyc);
    assign predSum = {1'b0, cnt_q} + {1'b0, sense_q};
    assign nextFast = (fastCnt_q[i] == 2'h0) ? fastDur_q :
                      dbl(fastDur_q, fastMaxCyc);
    assign nextFall = dbl(fallDur_q, fallMaxCyc);
    // Period minus last on time, floored at the minimum off time
    assign offCalc = (tswCyc > onLast_q + toffMinCyc) ?
                     tswCyc - onLast_q : toffMinCyc;
    assign slowLen = (fastCnt_q[i] >= 2'h2 && fastDur_q < offDur_q) ?
                     offDur_q - fastDur_q : offDur_q;
    // Init values follow registers, so they load on the first clock
    assign adaptClr = motorStopped | stepEvt[i].zeroCross |
                      ~primed_q;

    always_comb begin
      state_d = state_q[i];
      cnt_d = cnt_q;
      sense_d = sense_q;
      fastDur_d = fastDur_q;
      fallDur_d = fallDur_q;
      offDur_d = offDur_q;
      onLast_d = onLast_q;
      fastCnt_d = fastCnt_q[i];
      fallAct_d = fallAct_q;
      case (state_q[i])
        ppc_pkg::PPC_IDLE: begin
          state_d = ppc_pkg::PPC_ON;
          cnt_d = '0;
        end
        ppc_pkg::PPC_ON: begin
          cnt_d = (cnt_q == '1) ? cnt_q : cnt_q + TW'(1);
          if (senseHit[i]) begin
            sense_d = cnt_q;
            if (shortOn && fallAct_q) begin
              fallDur_d = nextFall;
              state_d = ppc_pkg::PPC_FALL;
              cnt_d = nextFall;
            end else if (shortOn) begin
              fastDur_d = nextFast;
              fastCnt_d = (fastCnt_q[i] == 2'h3) ? 2'h3 :
                          fastCnt_q[i] + 2'h1;
              state_d = ppc_pkg::PPC_FAST;
              cnt_d = nextFast;
            end else if (predEn) begin
              fallAct_d = 1'b0;
              state_d = ppc_pkg::PPC_PRED;
              cnt_d = atLeastOne(predSum[TW:1]);
              onLast_d = cnt_q + predSum[TW:1];
            end else begin
              fallAct_d = 1'b0;
              state_d = ppc_pkg::PPC_OFF_SLOW;
              cnt_d = slowLen;
              onLast_d = cnt_q;
            end
          end
        end
        ppc_pkg::PPC_PRED: begin
          cnt_d = cnt_q - TW'(1);
          if (cntDone) begin
            state_d = ppc_pkg::PPC_OFF_SLOW;
            cnt_d = slowLen;
          end
        end
        ppc_pkg::PPC_OFF_SLOW: begin
          cnt_d = cnt_q - TW'(1);
          if (cntDone && slowLen != offDur_q) begin
            state_d = ppc_pkg::PPC_OFF_FAST;
            cnt_d = fastDur_q;
          end else if (cntDone) begin
            state_d = ppc_pkg::PPC_ON;
            cnt_d = '0;
          end
        end
        default: begin
          // Fast decays of all three kinds (split off, short on, falling) end back in the on state
          cnt_d = cnt_q - TW'(1);
          if (cntDone) begin
            state_d = ppc_pkg::PPC_ON;
            cnt_d = '0;
          end
        end
      endcase
      if (stepEvt[i].stepRise) begin
        fastCnt_d = 2'h0;
        fastDur_d = atLeastOne(fastDur_q >> 1);
        offDur_d = offCalc;
      end
      if (stepEvt[i].stepFall) begin
        fallAct_d = 1'b1;
        offDur_d = offCalc;
        state_d = ppc_pkg::PPC_FALL;
        cnt_d = fallDur_q;
      end
      if (adaptClr) begin
        fastCnt_d = 2'h0;
        fastDur_d = fastInit;
        fallDur_d = fallInit;
        fallAct_d = 1'b0;
        offDur_d = toffMinCyc;
      end
      if (!bridgeEnable) begin
        state_d = ppc_pkg::PPC_IDLE;
      end
    end

    // Forward drive follows the commanded current sign
    always_comb begin
      gate_d = '0;
      case (state_d)
        ppc_pkg::PPC_ON, ppc_pkg::PPC_PRED: begin
          gate_d = stepEvt[i].sign ? 4'b0110 : 4'b1001;
        end
        ppc_pkg::PPC_OFF_SLOW: begin
          gate_d = 4'b0101;
        end
        ppc_pkg::PPC_OFF_FAST, ppc_pkg::PPC_FAST,
        ppc_pkg::PPC_FALL: begin
          gate_d = stepEvt[i].sign ? 4'b1001 : 4'b0110;
        end
        default: begin
          gate_d = '0;
        end
      endcase
    end

    always_ff @(posedge clk or negedge rstSyncN_q) begin
      if (!rstSyncN_q) begin
        state_q[i] <= ppc_pkg::PPC_IDLE;
        cnt_q <= '0;
        sense_q <= '0;
        fastDur_q <= TW'(1);
        fallDur_q <= TW'(1);
        offDur_q <= TW'(1);
        onLast_q <= '0;
        fastCnt_q[i] <= 2'h0;
        fallAct_q <= 1'b0;
        primed_q <= 1'b0;
        gate[i] <= '0;
      end else begin
        state_q[i] <= state_d;
        cnt_q <= cnt_d;
        sense_q <= sense_d;
        fastDur_q <= fastDur_d;
        fallDur_q <= fallDur_d;
        offDur_q <= offDur_d;
        onLast_q <= onLast_d;
        fastCnt_q[i] <= fastCnt_d;
        fallAct_q <= fallAct_d;
        primed_q <= 1'b1;
        gate[i] <= gate_d;
      end
    end
  end : gBridge

  assign statusWord = {7'h00, fastCnt_q[1], state_q[1],
                       7'h00, fastCnt_q[0], state_q[0]};

  // ****************************************************************
  // Ramp converter and amplitude selection
  // ****************************************************************
  logic [8:0] adcDiv_q;
  logic [4:0] adcConv_q;
  wire adcEnd = (adcDiv_q == 9'(`PPC_ADC_DIV - 1));

  // Ramp steps every 16 clocks; last code under the input is kept
  assign adcRamp = adcDiv_q[8:4];

  wire [6:0] ampSel = tqReg ? {adcOut_q, 2'h0} :
                      tval_q[motionPhase];

  always_ff @(posedge clk or negedge rstSyncN_q) begin
    if (!rstSyncN_q) begin
      adcDiv_q <= 9'h000;
      adcConv_q <= 5'h00;
      adcOut_q <= 5'h00;
      amplitude <= 7'h00;
    end else begin
      adcDiv_q <= adcDiv_q + 9'h001;
      amplitude <= ampSel;
      if (adcEnd) begin
        adcOut_q <= adcConv_q;
        adcConv_q <= 5'h00;
      end else if (adcAbove) begin
        adcConv_q <= adcRamp;
      end
    end
  end

endmodule : ppc_ctrl

// *** tb/ppc_ctrl_monitor.sv ***
`timescale 1ns/1ps
module ppc_ctrl_monitor (
  // System
  input wire logic clk,
  input wire logic rstn,
  // Register bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Bridges and converter
  input wire logic bridgeEnable,
  input wire ppc_pkg::ppc_step_s [1:0] stepEvt,
  input wire ppc_pkg::ppc_gate_s [1:0] gate,
  input wire logic [4:0] adcRamp
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // ****************************************************************
  // Register bus
  // ****************************************************************
  chk_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data not zero outside ack");

  // ****************************************************************
  // Bridges
  // ****************************************************************
  // Any other pattern shorts a half bridge or is undocumented
  chk_gate_legal_a: assert property (
    4'(gate[0]) inside {4'h0, 4'h5, 4'h6, 4'h9})
    else $error("illegal gate pattern on bridge 0");
  chk_gate_legal_b: assert property (
    4'(gate[1]) inside {4'h0, 4'h5, 4'h6, 4'h9})
    else $error("illegal gate pattern on bridge 1");
  chk_disable_off: assert property (!bridgeEnable [*3] |-> gate == '0)
    else $error("gates on while bridges disabled");

  // ****************************************************************
  // Converter ramp
  // ****************************************************************
  chk_ramp_step: assert property (
    $changed(adcRamp) |-> adcRamp == 5'($past(adcRamp) + 5'h01))
    else $error("ramp code skipped");
  // 32 codes of 16 clocks give one conversion per 512 clocks
  chk_ramp_period: assert property (
    $changed(adcRamp) |=> $stable(adcRamp) [*8] ##1
      $stable(adcRamp) [*7] ##1 $changed(adcRamp))
    else $error("ramp code period not 16 clocks");

  cov_slow: cover property (4'(gate[0]) == 4'h5);
  cov_fast: cover property (4'(gate[0]) == 4'h6 && !stepEvt[0].sign);
  cov_write: cover property (wb_ack_o && wb_we_i);
endmodule : ppc_ctrl_monitor

bind ppc_ctrl ppc_ctrl_monitor ppc_ctrl_monitor_inst (
  .clk(clk), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .bridgeEnable(bridgeEnable), .stepEvt(stepEvt), .gate(gate),
  .adcRamp(adcRamp));

// *** tb/ppc_bridge_model.sv ***
`timescale 1ns/1ps
module ppc_bridge_model (
  // Clock
  input wire logic clk,
  // Bridge drive
  input wire ppc_pkg::ppc_gate_s [1:0] gate,
  input wire logic [1:0] sign,
  input wire logic [3:0] riseRate,
  // Comparators
  output logic [1:0] senseHit
);
  // ****************************************************************
  // Phase current as a counter; threshold fixed at 200
  // ****************************************************************
  int level [2];
  logic [3:0] onPat;

  initial begin
    level[0] = 0;
    level[1] = 0;
    senseHit = 2'h0;
  end

  // Fast decay drops quicker than slow decay, as on a real coil
  always @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      onPat = sign[i] ? 4'h6 : 4'h9;
      if (4'(gate[i]) == onPat) begin
        level[i] = level[i] + int'(riseRate);
      end else if (4'(gate[i]) == (onPat ^ 4'hf)) begin
        level[i] = (level[i] > 4) ? level[i] - 4 : 0;
      end else begin
        level[i] = (level[i] > 2) ? level[i] - 2 : 0;
      end
      senseHit[i] <= (level[i] >= 200);
    end
  end
endmodule : ppc_bridge_model

// *** tb/ppc_ctrl_test.sv ***
`timescale 1ns/1ps
module ppc_ctrl_test;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic clk;
  logic rstn;
  logic wbCyc;
  logic wbStb;
  logic wbWe;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI;
  logic [31:0] wbDatO;
  logic wbAck;
  logic bridgeEnable;
  logic motorStopped;
  ppc_pkg::ppc_motion_e motionPhase;
  ppc_pkg::ppc_step_s [1:0] stepEvt;
  logic [1:0] senseHit;
  ppc_pkg::ppc_gate_s [1:0] gate;
  logic [6:0] amplitude;
  logic adcAbove;
  logic [4:0] adcRamp;
  logic [3:0] riseRate;
  logic [31:0] rd;
  int mismatches;
  int n_tests;
  logic [7:0] regAdr [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10,
                              8'h14, 8'h18, 8'h1c, 8'h20, 8'h2c};
  logic [31:0] regRst [10] = '{32'h0, 32'h19, 32'h29, 32'h29, 32'h0b,
                               32'h29, 32'h29, 32'h29, 32'h29, 32'h0};

  ppc_ctrl ppc_ctrl_inst (
    .clk(clk), .rstn(rstn), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .bridgeEnable(bridgeEnable), .motorStopped(motorStopped),
    .motionPhase(motionPhase), .stepEvt(stepEvt), .senseHit(senseHit),
    .gate(gate), .amplitude(amplitude), .adcAbove(adcAbove),
    .adcRamp(adcRamp));

  ppc_bridge_model ppc_bridge_model_inst (
    .clk(clk), .gate(gate), .sign({stepEvt[1].sign, stepEvt[0].sign}),
    .riseRate(riseRate), .senseHit(senseHit));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Request stands until the rising edge that sees ack high; data is
  // taken and the request dropped at that same edge
  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] dat, input logic [3:0] sel);
    int i;
    @(posedge clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    wbSel <= sel;
    i = 0;
    @(posedge clk);
    while (wbAck !== 1'b1 && i < 20) begin
      @(posedge clk);
      i++;
    end
    if (wbAck !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      tally_and_finish();
    end
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    wb_xfer(1'b1, adr, dat, 4'hf);
  endtask : wr

  task automatic rd_check(input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0, 4'hf);
    check(rd, exp);
  endtask : rd_check

  // Polls the status word until a bridge shows the wanted state
  task automatic wait_state(input logic [6:0] st, input int lsb);
    int i;
    i = 0;
    wb_xfer(1'b0, 8'h28, 32'h0, 4'hf);
    while (rd[lsb +: 7] !== st && i < 600) begin
      wb_xfer(1'b0, 8'h28, 32'h0, 4'hf);
      i++;
    end
    check(32'(rd[lsb +: 7]), 32'(st));
  endtask : wait_state

  task automatic pulse(input logic [2:0] ev);
    @(posedge clk);
    stepEvt[0] <= {ev, 1'b0};
    @(posedge clk);
    stepEvt[0] <= '0;
  endtask : pulse

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial begin
    rstn = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h0;
    wbDatI = 32'h0;
    bridgeEnable = 1'b1;
    motorStopped = 1'b0;
    motionPhase = ppc_pkg::PPC_MOT_STOP;
    stepEvt = '0;
    adcAbove = 1'b0;
    riseRate = 4'h1;
    mismatches = 0;
    n_tests = 0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    check(32'(amplitude), 32'h29);
    for (int k = 0; k < 10; k++) begin
      rd_check(regAdr[k], regRst[k]);
    end
    wr(8'h2c, 32'h7f);
    rd_check(8'h2c, 32'h0);
    wb_xfer(1'b1, 8'h10, 32'h1f, 4'he);
    rd_check(8'h10, 32'h0b);
    // Minimum on and off times of 50 clocks
    wr(8'h08, 32'h1);
    wr(8'h0c, 32'h1);
    wr(8'h14, 32'h10);
    wr(8'h1c, 32'h11);
    wr(8'h20, 32'h12);
    wr(8'h18, 32'h13);
    for (int k = 0; k < 4; k++) begin
      motionPhase <= ppc_pkg::ppc_motion_e'(k);
      repeat (3) @(posedge clk);
      check(32'(amplitude), 32'h10 + 32'(k));
    end
    adcAbove <= 1'b1;
    wr(8'h00, 32'h2);
    repeat (1100) @(posedge clk);
    rd_check(8'h24, 32'h1f);
    check(32'(amplitude), 32'h7c);
    wr(8'h00, 32'h0);
    repeat (3) @(posedge clk);
    check(32'(amplitude), 32'h13);
    wait_state(7'h08, 0);
    check(32'(gate[0]), 32'h5);
    wait_state(7'h08, 16);
    wr(8'h00, 32'h1);
    wait_state(7'h04, 0);
    check(32'(gate[0]), 32'h9);
    wr(8'h00, 32'h0);
    riseRate <= 4'h8;
    wait_state(7'h20, 0);
    check(32'(gate[0]), 32'h6);
    repeat (1000) @(posedge clk);
    riseRate <= 4'h1;
    wait_state(7'h10, 0);
    pulse(3'b100);
    wb_xfer(1'b0, 8'h28, 32'h0, 4'hf);
    check(32'(rd[8:7]), 32'h0);
    riseRate <= 4'h8;
    wait_state(7'h20, 0);
    check(32'(rd[8:7]), 32'h1);
    riseRate <= 4'h1;
    pulse(3'b001);
    wb_xfer(1'b0, 8'h28, 32'h0, 4'hf);
    check(32'(rd[8:7]), 32'h0);
    pulse(3'b010);
    wb_xfer(1'b0, 8'h28, 32'h0, 4'hf);
    check(32'(rd[6:0]), 32'h40);
    bridgeEnable <= 1'b0;
    repeat (4) @(posedge clk);
    check(32'(gate), 32'h0);
    tally_and_finish();
  end
endmodule : ppc_ctrl_test
